/* File: rtl/svw_params.svh */
// constants for the supervisor pin and watchdog block
`ifndef SVW_PARAMS_SVH
`define SVW_PARAMS_SVH

`define SVW_CLK_PERIOD_NS 4
`define SVW_TICK_TIME_NS 1000
`define SVW_TICK_CYCLES (`SVW_TICK_TIME_NS / `SVW_CLK_PERIOD_NS)
`define SVW_TICK_W 8
`define SVW_CNT_W 24
`define SVW_HOLD_TIME_MS 200
`define SVW_HOLD_TICKS (`SVW_HOLD_TIME_MS * 1000)
`define SVW_WRITE_TIME_MS 5
`define SVW_WRITE_TICKS (`SVW_WRITE_TIME_MS * 1000)
`define SVW_WDT_TICKS0 1000000
`define SVW_WDT_TICKS1 500000
`define SVW_WDT_TICKS2 100000

`define SVW_OP_WREN 8'h06
`define SVW_OP_SFLB 8'h00
`define SVW_OP_WRDI 8'h04
`define SVW_OP_RDSR 8'h05
`define SVW_OP_WRSR 8'h01

`define SVW_SR_LOCK 7
`define SVW_SR_WD_HI 5
`define SVW_SR_WD_LO 4
`define SVW_SR_BP_HI 3
`define SVW_SR_BP_LO 2
`define SVW_WD_OFF 2'h3
`define SVW_WD_RESET 2'h0
`define SVW_BP_RESET 2'h0
`define SVW_LOCK_RESET 1'h0

`define SVW_SYNC_W 5
`define SVW_SYNC_RESET 5'h11
`define SVW_IX_CS 4
`define SVW_IX_SCK 3
`define SVW_IX_SI 2
`define SVW_IX_VOK 1
`define SVW_IX_WP 0
`define SVW_LAST_BIT 3'h7

`endif

/* File: rtl/svw_pkg.sv */
// types for the supervisor pin and watchdog block
package svw_pkg;
  typedef enum logic [1:0] {
    SVW_CMD = 2'h0,
    SVW_RD = 2'h1,
    SVW_WR = 2'h3,
    SVW_DONE = 2'h2
  } svw_state_t;
endpackage

/* File: rtl/svw_pin_watchdog.sv */
// supervisor pins: serial status access, watchdog on the select pin, open-drain reset
`timescale 1ns/1ns
`include "svw_params.svh"

module svw_pin_watchdog
  import svw_pkg::*;
#(
  parameter logic [`SVW_CNT_W-1:0] HOLD_TICKS = `SVW_HOLD_TICKS,
  parameter logic [`SVW_CNT_W-1:0] WRITE_TICKS = `SVW_WRITE_TICKS,
  parameter logic [`SVW_CNT_W-1:0] WDT_TICKS0 = `SVW_WDT_TICKS0,
  parameter logic [`SVW_CNT_W-1:0] WDT_TICKS1 = `SVW_WDT_TICKS1,
  parameter logic [`SVW_CNT_W-1:0] WDT_TICKS2 = `SVW_WDT_TICKS2,
  parameter bit ACTIVE_HIGH_RESET = 1'b0
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic selectKickPin_n,
  input wire logic serialClk,
  input wire logic serialIn,
  input wire logic writeProtect_n,
  input wire logic supplyAboveTrip,
  input wire logic resetPinIn,
  output logic serialOut,
  output logic serialOutOe_n,
  output logic resetPinOut,
  output logic resetPinOe_n,
  output logic activePower
);

  // time-out selection, 11 switches the watchdog off
  function automatic logic [`SVW_CNT_W-1:0] wdPeriod(input logic [1:0] sel);
    logic [`SVW_CNT_W-1:0] p;
    p = WDT_TICKS0;
    case (sel)
      2'h1: p = WDT_TICKS1;
      2'h2: p = WDT_TICKS2;
      default: p = WDT_TICKS0;
    endcase
    return p;
  endfunction

  logic [`SVW_SYNC_W-1:0] rawIn;
  logic [`SVW_SYNC_W-1:0] syncA;
  logic [`SVW_SYNC_W-1:0] syncB;
  logic [`SVW_SYNC_W-1:0] syncPrev;
  logic [`SVW_TICK_W-1:0] tickCnt;
  logic tick;
  logic resetActive;
  logic [`SVW_CNT_W-1:0] holdCnt;
  logic [`SVW_CNT_W-1:0] wdCnt;
  logic armed;
  svw_state_t state;
  logic [2:0] bitCnt;
  logic [7:0] shiftIn;
  logic [2:0] outIdx;
  logic soBit;
  logic [7:0] wrData;
  logic wrPending;
  logic lockBit;
  logic flagBit;
  logic [1:0] wdSel;
  logic [1:0] blockProt;
  logic wel;
  logic wip;
  logic [`SVW_CNT_W-1:0] writeCnt;

  assign rawIn = {selectKickPin_n, serialClk, serialIn, supplyAboveTrip, writeProtect_n};

  // per-pin reset levels, idle select high so no false kick follows reset
  localparam logic [`SVW_SYNC_W-1:0] SYNC_INIT = `SVW_SYNC_RESET;

  // pins from outside the clock domain: two flops before any use
  genvar gi;
  generate
    for (gi = 0; gi < `SVW_SYNC_W; gi++) begin : gSync
      always_ff @(posedge clk) begin
        if (!rst_n) begin
          syncA[gi] <= SYNC_INIT[gi];
          syncB[gi] <= SYNC_INIT[gi];
          syncPrev[gi] <= SYNC_INIT[gi];
        end else begin
          syncA[gi] <= rawIn[gi];
          syncB[gi] <= syncA[gi];
          syncPrev[gi] <= syncB[gi];
        end
      end
    end
  endgenerate

  wire csHigh = syncB[`SVW_IX_CS];
  wire csFall = syncPrev[`SVW_IX_CS] & ~syncB[`SVW_IX_CS];
  wire csRise = ~syncPrev[`SVW_IX_CS] & syncB[`SVW_IX_CS];
  wire sckRise = ~syncPrev[`SVW_IX_SCK] & syncB[`SVW_IX_SCK];
  wire sckFall = syncPrev[`SVW_IX_SCK] & ~syncB[`SVW_IX_SCK];
  wire siBit = syncB[`SVW_IX_SI];
  wire supplyOk = syncB[`SVW_IX_VOK];
  wire wpHigh = syncB[`SVW_IX_WP];

  wire tickWrap = (tickCnt == `SVW_TICK_W'(`SVW_TICK_CYCLES - 1));
  always_ff @(posedge clk) begin
    if (!rst_n || tickWrap) begin
      tickCnt <= '0;
    end else begin
      tickCnt <= tickCnt + `SVW_TICK_W'(1);
    end
  end
  assign tick = tickWrap;

  wire wdEnabled = (wdSel != `SVW_WD_OFF);
  wire [`SVW_CNT_W-1:0] wdLimit = wdPeriod(wdSel);
  // expiry without a kick; stuck level of either polarity counts alike
  wire wdExpire = wdEnabled && !resetActive && !csFall && (wdCnt >= wdLimit);
  wire holdDone = (holdCnt == HOLD_TICKS - `SVW_CNT_W'(1));

  // falling select restarts the count from zero
  always_ff @(posedge clk) begin
    if (!rst_n || resetActive || csFall || !wdEnabled) begin
      wdCnt <= '0;
    end else if (tick) begin
      wdCnt <= wdCnt + `SVW_CNT_W'(1);
    end
  end

  // active from power-up; supply low; hold after recovery
  always_ff @(posedge clk) begin
    if (!rst_n || !supplyOk || wdExpire) begin
      resetActive <= 1'b1;
      holdCnt <= '0;
    end else if (resetActive && tick) begin
      resetActive <= !holdDone;
      holdCnt <= holdDone ? '0 : holdCnt + `SVW_CNT_W'(1);
    end
  end

  // nothing accepted until the first falling select
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      armed <= 1'b0;
    end else if (csFall) begin
      armed <= 1'b1;
    end
  end

  wire selected = !csHigh && armed && !resetActive;
  wire bitTake = selected && sckRise;
  wire byteDone = bitTake && (bitCnt == `SVW_LAST_BIT);
  // bytes arrive most significant bit first
  wire [7:0] rxByte = {shiftIn[6:0], siBit};
  wire cmdDone = byteDone && (state == SVW_CMD);
  wire opWren = cmdDone && (rxByte == `SVW_OP_WREN) && !wip;
  wire opWrdi = cmdDone && (rxByte == `SVW_OP_WRDI);
  wire opSflb = cmdDone && (rxByte == `SVW_OP_SFLB);
  wire opRdsr = cmdDone && (rxByte == `SVW_OP_RDSR);
  wire opWrsr = cmdDone && (rxByte == `SVW_OP_WRSR) && wel && !wip;
  // low protect pin with lock bit set freezes the settings
  wire locked = lockBit && !wpHigh;
  wire commitWr = csRise && wrPending && !resetActive && !locked;
  wire writeEnd = wip && tick && (writeCnt == WRITE_TICKS - `SVW_CNT_W'(1));
  wire [7:0] statusWord = {lockBit, flagBit, wdSel, blockProt, wel, wip};

  // bits taken on serial clock rising edge
  always_ff @(posedge clk) begin
    if (!rst_n || csFall) begin
      bitCnt <= '0;
      shiftIn <= '0;
    end else if (bitTake) begin
      bitCnt <= bitCnt + 3'h1;
      shiftIn <= rxByte;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n || csFall || resetActive) begin
      state <= SVW_CMD;
    end else if (byteDone) begin
      case (state)
        SVW_CMD: state <= opRdsr ? SVW_RD : (opWrsr ? SVW_WR : SVW_DONE);
        SVW_RD: state <= SVW_RD;
        SVW_WR: state <= SVW_DONE;
        default: state <= SVW_DONE;
      endcase
    end
  end

  // status write only lands when select returns high after a whole byte
  always_ff @(posedge clk) begin
    if (!rst_n || csFall || resetActive || csRise) begin
      wrPending <= 1'b0;
      wrData <= '0;
    end else if (byteDone && state == SVW_WR) begin
      wrPending <= 1'b1;
      wrData <= rxByte;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      lockBit <= `SVW_LOCK_RESET;
      wdSel <= `SVW_WD_RESET;
      blockProt <= `SVW_BP_RESET;
    end else if (commitWr) begin
      lockBit <= wrData[`SVW_SR_LOCK];
      wdSel <= wrData[`SVW_SR_WD_HI:`SVW_SR_WD_LO];
      blockProt <= wrData[`SVW_SR_BP_HI:`SVW_SR_BP_LO];
    end
  end

  // latch clears after a finished write; a new set in that cycle is impossible while busy
  always_ff @(posedge clk) begin
    if (!rst_n || opWrdi || writeEnd) begin
      wel <= 1'b0;
    end else if (opWren) begin
      wel <= 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n || opWrdi) begin
      flagBit <= 1'b0;
    end else if (opSflb) begin
      flagBit <= 1'b1;
    end
  end

  // self-timed nonvolatile cycle after a status write
  always_ff @(posedge clk) begin
    if (!rst_n || writeEnd) begin
      wip <= 1'b0;
      writeCnt <= '0;
    end else if (commitWr) begin
      wip <= 1'b1;
      writeCnt <= '0;
    end else if (wip && tick) begin
      writeCnt <= writeCnt + `SVW_CNT_W'(1);
    end
  end

  // output bit moves on serial clock falling edge
  always_ff @(posedge clk) begin
    if (!rst_n || csFall) begin
      outIdx <= `SVW_LAST_BIT;
      soBit <= 1'b0;
    end else if (selected && sckFall && state == SVW_RD) begin
      soBit <= statusWord[outIdx];
      outIdx <= outIdx - 3'h1;
    end
  end

  assign serialOut = soBit;
  // released whenever not selected or not reading
  assign serialOutOe_n = !(selected && state == SVW_RD);
  // standby only when deselected and not busy writing
  assign activePower = !csHigh || wip;
  // open drain: pulls low while active-low reset is active, or while active-high reset is idle
  assign resetPinOut = 1'b0;
  assign resetPinOe_n = ACTIVE_HIGH_RESET ? resetActive : !resetActive;

endmodule

/* File: tb/svw_pin_assertions.sv */
// port checks for the supervisor pin block
`timescale 1ns/1ns
module svw_pin_assertions #(
  parameter int HOLD_TICKS = 20,
  parameter int WDT_TICKS0 = 40,
  parameter int WDT_TICKS2 = 20,
  parameter bit ACTIVE_HIGH_RESET = 1'b0
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic selectKickPin_n,
  input wire logic serialClk,
  input wire logic supplyAboveTrip,
  input wire logic serialOut,
  input wire logic serialOutOe_n,
  input wire logic resetPinOe_n,
  input wire logic activePower
);
  localparam int T = 250;
  logic rstAct;
  int upCnt, holdCnt, idleCnt;
  assign rstAct = (resetPinOe_n == ACTIVE_HIGH_RESET);
  // sync and tick alignment add up to one tick, hence the slack
  always_ff @(posedge clk) begin
    upCnt <= (!rst_n || !supplyAboveTrip) ? 0 : upCnt + 1;
    holdCnt <= (rst_n && rstAct && supplyAboveTrip) ? holdCnt + 1 : 0;
    idleCnt <= (!rst_n || rstAct || $fell(selectKickPin_n)) ? 0 : idleCnt + 1;
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  a_select_release: assert property (selectKickPin_n [*5] |-> serialOutOe_n)
    else $error("output driven while deselected");
  a_active_power: assert property (!selectKickPin_n [*5] |-> activePower)
    else $error("no active power while selected");
  a_supply_low: assert property (!supplyAboveTrip [*4] |-> rstAct)
    else $error("no reset on low supply");
  a_hold_min: assert property ($fell(rstAct) |-> upCnt >= (HOLD_TICKS - 1) * T)
    else $error("reset released early");
  a_hold_max: assert property (holdCnt <= HOLD_TICKS * T + 300)
    else $error("reset held too long");
  a_kick_bound: assert property (idleCnt <= WDT_TICKS0 * T + 300)
    else $error("watchdog did not expire");
  a_kick_min: assert property ($rose(rstAct) && $past(supplyAboveTrip, 4) && supplyAboveTrip
    |-> idleCnt >= (WDT_TICKS2 - 1) * T)
    else $error("watchdog expired early");
  a_out_on_fall: assert property ($changed(serialOut) && !serialOutOe_n |-> !serialClk && !$past(serialClk, 2))
    else $error("output moved off falling clock");
endmodule
bind svw_pin_watchdog svw_pin_assertions #(.HOLD_TICKS(HOLD_TICKS), .WDT_TICKS0(WDT_TICKS0),
  .WDT_TICKS2(WDT_TICKS2), .ACTIVE_HIGH_RESET(ACTIVE_HIGH_RESET)) chk_u (.clk(clk), .rst_n(rst_n),
  .selectKickPin_n(selectKickPin_n), .serialClk(serialClk), .supplyAboveTrip(supplyAboveTrip),
  .serialOut(serialOut), .serialOutOe_n(serialOutOe_n), .resetPinOe_n(resetPinOe_n), .activePower(activePower));

/* File: tb/svw_host_model.sv */
// host side of the serial link, mode 0,0, 68 ns clock
`timescale 1ns/1ns
module svw_host_model (
  input wire logic clk,
  input wire logic soWire,
  output logic selectKick_n,
  output logic sck,
  output logic mosi
);
  initial begin
    selectKick_n = 1'b1;
    sck = 1'b0;
    mosi = 1'b0;
  end
  // select edges open frames and kick
  task automatic frame(input logic lvl);
    @(posedge clk) selectKick_n <= lvl;
    repeat (8) @(posedge clk);
  endtask
  task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
    for (int i = 7; i >= 0; i--) begin
      @(posedge clk) mosi <= tx[i];
      repeat (8) @(posedge clk);
      sck <= 1'b1;
      rx[i] = soWire;
      repeat (8) @(posedge clk);
      sck <= 1'b0;
    end
  endtask
endmodule

/* File: tb/tb_top.sv */
// bench for the supervisor pin block
`timescale 1ns/1ns
module tb_top;
  localparam int T = 250;
  logic clk, rst_n, writeProtect_n, supplyAboveTrip, lastSo, soWire, rstWire;
  logic selN, sck, mosi, serialOut, serialOutOe_n, resetPinOut, resetPinOe_n, activePower;
  logic [7:0] rx;
  int miscompares, cmpCount, cycles, n;
  // a released line toggles so a stale bit never reads as valid
  assign soWire = serialOutOe_n ? ~lastSo : serialOut;
  assign rstWire = resetPinOe_n ? 1'b1 : resetPinOut;
  svw_pin_watchdog #(.HOLD_TICKS(20), .WRITE_TICKS(8), .WDT_TICKS0(40), .WDT_TICKS1(30), .WDT_TICKS2(20)) dut_u (
    .clk(clk), .rst_n(rst_n), .selectKickPin_n(selN), .serialClk(sck), .serialIn(mosi),
    .writeProtect_n(writeProtect_n), .supplyAboveTrip(supplyAboveTrip), .resetPinIn(rstWire),
    .serialOut(serialOut), .serialOutOe_n(serialOutOe_n), .resetPinOut(resetPinOut),
    .resetPinOe_n(resetPinOe_n), .activePower(activePower));
  svw_host_model host_u (.clk(clk), .soWire(soWire), .selectKick_n(selN), .sck(sck), .mosi(mosi));
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  task automatic stop_test();
    $display("mismatches %0d compares %0d", miscompares, cmpCount);
    if (miscompares == 0 && cmpCount > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  always @(posedge clk) begin
    lastSo <= soWire;
    cycles++;
    if (cycles == 80000) begin
      miscompares++;
      stop_test();
    end
  end
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    cmpCount++;
    if (seen !== exp) begin
      miscompares++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic waitRst(input logic lvl, input int lim);
    n = 0;
    while (rstWire !== lvl && n < lim) begin
      @(posedge clk);
      n++;
    end
  endtask
  task automatic rdStatus();
    host_u.frame(1'b0);
    host_u.xfer(8'h05, rx);
    host_u.xfer(8'h00, rx);
    host_u.frame(1'b1);
  endtask
  task automatic wrStatus(input logic [7:0] v);
    host_u.frame(1'b0);
    host_u.xfer(8'h06, rx);
    host_u.frame(1'b1);
    host_u.frame(1'b0);
    host_u.xfer(8'h01, rx);
    host_u.xfer(v, rx);
    host_u.frame(1'b1);
    repeat (9 * T) @(posedge clk);
  endtask
  task automatic tPowerUp();
    host_u.frame(1'b0);
    check(rstWire, 1'b0);
    host_u.xfer(8'h05, rx);
    check(serialOutOe_n, 1'b1);
    host_u.frame(1'b1);
    waitRst(1'b1, 21 * T + 300);
    check(n >= 19 * T - 300 && rstWire === 1'b1, 1'b1);
  endtask
  task automatic tStatus();
    host_u.frame(1'b0);
    check(activePower, 1'b1);
    host_u.xfer(8'h05, rx);
    host_u.xfer(8'h00, rx);
    check(rx, 8'h00);
    host_u.frame(1'b1);
    check(activePower, 1'b0);
    check(serialOutOe_n, 1'b1);
  endtask
  task automatic tLock();
    wrStatus(8'h9c);
    rdStatus();
    check(rx, 8'h9c);
    writeProtect_n <= 1'b0;
    wrStatus(8'h00);
    rdStatus();
    check(rx & 8'hfd, 8'h9c);
    writeProtect_n <= 1'b1;
  endtask
  task automatic tWatchdog();
    repeat (3) begin
      repeat (20 * T) @(posedge clk);
      host_u.frame(1'b0);
      host_u.frame(1'b1);
    end
    check(rstWire, 1'b1);
    waitRst(1'b0, 40 * T);
    check(n >= 29 * T - 20 && n <= 30 * T + 300, 1'b1);
    waitRst(1'b1, 21 * T + 300);
  endtask
  task automatic tSupply();
    supplyAboveTrip <= 1'b0;
    repeat (5) @(posedge clk);
    check(rstWire, 1'b0);
    repeat (100) @(posedge clk);
    supplyAboveTrip <= 1'b1;
    waitRst(1'b1, 21 * T + 300);
    check(n >= 19 * T && n <= 20 * T + 300, 1'b1);
  endtask
  initial begin
    rst_n = 1'b0;
    writeProtect_n = 1'b1;
    supplyAboveTrip = 1'b1;
    lastSo = 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    tPowerUp();
    tStatus();
    tLock();
    tWatchdog();
    tSupply();
    stop_test();
  end
endmodule
